// [spd_engine_regs.vh]
// constants for the single-pin debug instruction engine
`ifndef SPD_ENGINE_REGS_VH
`define SPD_ENGINE_REGS_VH

// ------------------------------------------------------------
// instruction byte layout
// ------------------------------------------------------------
`define SPD_OP_HI 7
`define SPD_OP_LO 5
`define SPD_MODE_HI 3
`define SPD_MODE_LO 2
`define SPD_SIZE_HI 1
`define SPD_SIZE_LO 0
`define SPD_CSADR_HI 3
`define SPD_CSADR_LO 0
`define SPD_SIB_BIT 2

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define SPD_OP_DIRECT_LOAD 3'h0
`define SPD_OP_INDIRECT_LOAD 3'h1
`define SPD_OP_DIRECT_STORE 3'h2
`define SPD_OP_INDIRECT_STORE 3'h3
`define SPD_OP_CS_LOAD 3'h4
`define SPD_OP_REPEAT 3'h5
`define SPD_OP_CS_STORE 3'h6
`define SPD_OP_KEY 3'h7

// ------------------------------------------------------------
// pointer modes, sizes
// ------------------------------------------------------------
`define SPD_PTR_AT 2'h0
`define SPD_PTR_POSTINC 2'h1
`define SPD_PTR_LOAD 2'h2
`define SPD_SIZE_BYTE 2'h0
`define SPD_SIZE_WORD 2'h1
`define SPD_KEY_BYTES_64 4'h7
`define SPD_SIB_BYTES_64 4'h7
`define SPD_SIB_BYTES_128 4'hf

// ------------------------------------------------------------
// characters
// ------------------------------------------------------------
`define SPD_SYNC_CHAR 8'h55
`define SPD_ACK_CHAR 8'h40

// ------------------------------------------------------------
// control/status space
// ------------------------------------------------------------
`define SPD_CS_STATUS 4'h0
`define SPD_CS_GUARD 4'h2
`define SPD_CS_DELAY 4'h3
`define SPD_GUARD_HI 2
`define SPD_GUARD_LO 0
`define SPD_INTERBYTE_DELAY_ENABLE_BIT 7
`define SPD_CS_RESET 8'h00
`define SPD_GUARD_RESET 8'h00
`define SPD_GUARD_NONE 3'h7

// ------------------------------------------------------------
// timing, in bit times
// ------------------------------------------------------------
`define SPD_IB_EXTRA_BITS 8'h02

`endif

// [spd_engine.v]
// instruction engine of the single-pin debug port
//
// What this block does
// (R1) indirect store writes data at pointer address
// (R2) pointer mode two loads pointer, then acknowledge
// (R3) mode zero writes pointer; one post-increments
// (R4) acknowledge after each successful indirect store
// (R5) debugger sends next frame after acknowledge
// (R6) cs load: opcode address, one byte
// (R7) cs load byte sent after guard time
// (R8) cs store: opcode address, one byte
// (R9) no response after cs store
// (R10) repeat count from one byte only
// (R11) repeated instruction runs count plus one
// (R12) only first repetition has sync and instruction
// (R13) only break aborts an ongoing repeat
// (R14) debugger uses post-increment with repeat
// (R15) debugger resends direct address each iteration
// (R16) key entry accepts only 64-bit keys
// (R17) info-block select bit sends system information
// (R18) key size sets frame count
// (R19) nothing sent back after key bytes
// (R20) info block starts after guard time
// (R21) interbyte delay adds two extra stop bits
// (R22) first byte gets guard time only
// (R23) guard idle bits on every turnaround
// (R24) debugger sends sync before each instruction
// (R25) break clears repeat count, awaits sync
`include "spd_engine_regs.vh"

module spd_engine (
    input wire core_clk,
    input wire rst,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_break,
    input wire bit_tick,
    input wire tx_ready,
    output reg tx_valid,
    output reg [7:0] tx_data,
    output reg bus_req,
    output reg [15:0] bus_addr,
    output reg [15:0] bus_wdata,
    output reg bus_word,
    input wire bus_ack,
    output reg [7:0] key_byte,
    output reg key_valid,
    output reg key_done,
    input wire [127:0] sib_data,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [8:0] S_SYNC = 9'h001;
    localparam [8:0] S_INSTR = 9'h002;
    localparam [8:0] S_DEC = 9'h004;
    localparam [8:0] S_OPND = 9'h008;
    localparam [8:0] S_BUS = 9'h010;
    localparam [8:0] S_GUARD = 9'h020;
    localparam [8:0] S_SEND = 9'h040;
    localparam [8:0] S_GAP = 9'h080;
    localparam [8:0] S_KEY = 9'h100;

    localparam [1:0] TX_ACK = 2'h0;
    localparam [1:0] TX_CS = 2'h1;
    localparam [1:0] TX_SIB = 2'h2;

    reg [8:0] state;
    reg [7:0] instr;
    reg [7:0] rpt_cnt;
    reg rpt_arm;
    reg rpt_run;
    reg [15:0] ptr;
    reg [7:0] opnd_lo;
    reg [3:0] byte_cnt;
    reg [3:0] need;
    reg [7:0] tick_cnt;
    reg [1:0] tx_kind;
    reg [3:0] tx_idx;
    reg [3:0] tx_left;
    reg cs_dbg_wr;
    reg [7:0] cs_dbg_data;
    reg [7:0] cs_mem [0:15];

    wire [2:0] op = instr[`SPD_OP_HI:`SPD_OP_LO];
    wire [1:0] mode = instr[`SPD_MODE_HI:`SPD_MODE_LO];
    wire [1:0] size = instr[`SPD_SIZE_HI:`SPD_SIZE_LO];
    wire [3:0] cs_adr = instr[`SPD_CSADR_HI:`SPD_CSADR_LO];
    wire [2:0] guard_time_setting = cs_mem[`SPD_CS_GUARD][`SPD_GUARD_HI:`SPD_GUARD_LO];
    wire interbyte_delay_enable = cs_mem[`SPD_CS_DELAY][`SPD_INTERBYTE_DELAY_ENABLE_BIT];
    wire [15:0] opnd_full = (need != 4'h0) ? {rx_data, opnd_lo} : {8'h00, rx_data};

    // ------------------------------------------------------------
    // control/status space
    // ------------------------------------------------------------
    wire [7:0] status_view = {rpt_run, rpt_arm, bus_req, tx_valid, 4'h0};
    wire [7:0] cs_view [0:15];

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_cs
            wire dbg_hit = cs_dbg_wr && (cs_adr == gi[3:0]);
            wire sw_hit = reg_wr && (reg_addr == gi[3:0]);
            always @(posedge core_clk) begin
                if (rst) begin
                    cs_mem[gi] <= (gi == `SPD_CS_GUARD) ? `SPD_GUARD_RESET : `SPD_CS_RESET;
                end else if (dbg_hit) begin
                    cs_mem[gi] <= cs_dbg_data; // [R8]
                end else if (sw_hit) begin
                    cs_mem[gi] <= reg_wdata;
                end
            end
            assign cs_view[gi] = (gi == `SPD_CS_STATUS) ? status_view : cs_mem[gi];
        end
    endgenerate

    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= cs_view[reg_addr];
        end
    end

    // ------------------------------------------------------------
    // guard time in idle bits
    // ------------------------------------------------------------
    reg [7:0] guard_bits;
    always @* begin
        if (guard_time_setting == `SPD_GUARD_NONE) begin
            guard_bits = 8'h00;
        end else begin
            guard_bits = 8'h80 >> guard_time_setting; // [R23]
        end
    end

    // next outgoing byte
    reg [7:0] next_tx_byte;
    always @* begin
        case (tx_kind)
            TX_CS: next_tx_byte = cs_view[cs_adr];
            TX_SIB: next_tx_byte = sib_data[{tx_idx, 3'h0} +: 8];
            default: next_tx_byte = `SPD_ACK_CHAR;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst || rx_break) begin
            state <= S_SYNC; // [R13] [R25]
            instr <= 8'h00;
            rpt_cnt <= 8'h00;
            rpt_arm <= 1'b0;
            rpt_run <= 1'b0;
            opnd_lo <= 8'h00;
            byte_cnt <= 4'h0;
            need <= 4'h0;
            tick_cnt <= 8'h00;
            tx_kind <= TX_ACK;
            tx_idx <= 4'h0;
            tx_left <= 4'h0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            bus_req <= 1'b0;
            cs_dbg_wr <= 1'b0;
            cs_dbg_data <= 8'h00;
            key_valid <= 1'b0;
            key_done <= 1'b0;
            if (rst) begin
                ptr <= 16'h0000;
                bus_addr <= 16'h0000;
                bus_wdata <= 16'h0000;
                bus_word <= 1'b0;
                key_byte <= 8'h00;
            end
        end else begin
            cs_dbg_wr <= 1'b0;
            key_valid <= 1'b0;
            key_done <= 1'b0;
            case (state)
                S_SYNC: begin
                    if (rx_valid && rx_data == `SPD_SYNC_CHAR) begin
                        state <= S_INSTR;
                    end
                end
                S_INSTR: begin
                    if (rx_valid) begin
                        instr <= rx_data;
                        rpt_run <= rpt_arm;
                        rpt_arm <= 1'b0;
                        state <= S_DEC;
                    end
                end
                S_DEC: begin
                    byte_cnt <= 4'h0;
                    tick_cnt <= 8'h00;
                    tx_idx <= 4'h0;
                    state <= S_SYNC;
                    case (op)
                        `SPD_OP_INDIRECT_STORE: begin
                            if (mode != 2'h3 && size[1] == 1'b0) begin
                                need <= {3'h0, size[0]}; // [R1] [R2]
                                state <= S_OPND;
                            end else begin
                                rpt_run <= 1'b0;
                            end
                        end
                        `SPD_OP_CS_STORE: begin
                            need <= 4'h0; // [R8]
                            state <= S_OPND;
                        end
                        `SPD_OP_CS_LOAD: begin
                            tx_kind <= TX_CS; // [R6]
                            tx_left <= 4'h0;
                            state <= S_GUARD; // [R7]
                        end
                        `SPD_OP_REPEAT: begin
                            if (size == `SPD_SIZE_BYTE) begin
                                need <= 4'h0; // [R10]
                                state <= S_OPND;
                            end
                            rpt_run <= 1'b0;
                        end
                        `SPD_OP_KEY: begin
                            if (instr[`SPD_SIB_BIT] && size[1] == 1'b0) begin
                                tx_kind <= TX_SIB; // [R17] [R18]
                                tx_left <= size[0] ? `SPD_SIB_BYTES_128 : `SPD_SIB_BYTES_64;
                                state <= S_GUARD; // [R20]
                            end else if (!instr[`SPD_SIB_BIT] && size == `SPD_SIZE_BYTE) begin
                                need <= `SPD_KEY_BYTES_64; // [R16] [R18]
                                state <= S_KEY;
                            end else begin
                                rpt_run <= 1'b0;
                            end
                        end
                        default: begin
                            rpt_run <= 1'b0;
                        end
                    endcase
                end
                S_OPND: begin
                    if (rx_valid) begin
                        opnd_lo <= rx_data;
                        byte_cnt <= byte_cnt + 4'h1;
                        if (byte_cnt == need) begin
                            case (op)
                                `SPD_OP_INDIRECT_STORE: begin
                                    if (mode == `SPD_PTR_LOAD) begin
                                        ptr <= opnd_full; // [R2]
                                        tx_kind <= TX_ACK; // [R4]
                                        tx_left <= 4'h0;
                                        state <= S_GUARD;
                                    end else begin
                                        bus_addr <= ptr; // [R1] [R3]
                                        bus_wdata <= opnd_full;
                                        bus_word <= need[0];
                                        bus_req <= 1'b1;
                                        state <= S_BUS;
                                    end
                                end
                                `SPD_OP_CS_STORE: begin
                                    cs_dbg_wr <= 1'b1;
                                    cs_dbg_data <= rx_data;
                                    if (rpt_run && rpt_cnt != 8'h00) begin
                                        rpt_cnt <= rpt_cnt - 8'h01; // [R11] [R12]
                                        state <= S_DEC;
                                    end else begin
                                        rpt_run <= 1'b0;
                                        state <= S_SYNC; // [R9]
                                    end
                                end
                                default: begin
                                    rpt_cnt <= rx_data; // [R10]
                                    rpt_arm <= 1'b1;
                                    state <= S_SYNC;
                                end
                            endcase
                        end
                    end
                end
                S_BUS: begin
                    if (bus_ack) begin
                        bus_req <= 1'b0;
                        if (mode == `SPD_PTR_POSTINC) begin
                            ptr <= ptr + {15'h0000, bus_word} + 16'h0001; // [R3]
                        end
                        tx_kind <= TX_ACK; // [R4]
                        tx_left <= 4'h0;
                        tick_cnt <= 8'h00;
                        state <= S_GUARD;
                    end
                end
                S_GUARD: begin
                    if (tick_cnt >= guard_bits) begin
                        tx_valid <= 1'b1; // [R22]
                        tx_data <= next_tx_byte;
                        state <= S_SEND;
                    end else if (bit_tick) begin
                        tick_cnt <= tick_cnt + 8'h01; // [R23]
                    end
                end
                S_SEND: begin
                    if (tx_ready) begin
                        tx_valid <= 1'b0;
                        tick_cnt <= 8'h00;
                        if (tx_left == 4'h0) begin
                            byte_cnt <= 4'h0;
                            if (rpt_run && rpt_cnt != 8'h00) begin
                                rpt_cnt <= rpt_cnt - 8'h01; // [R11] [R12]
                                state <= S_DEC;
                            end else begin
                                rpt_run <= 1'b0;
                                state <= S_SYNC;
                            end
                        end else begin
                            tx_idx <= tx_idx + 4'h1;
                            tx_left <= tx_left - 4'h1;
                            state <= S_GAP;
                        end
                    end
                end
                S_GAP: begin
                    if (tx_ready) begin
                        if (!interbyte_delay_enable || tick_cnt == `SPD_IB_EXTRA_BITS) begin
                            tx_valid <= 1'b1; // [R21]
                            tx_data <= next_tx_byte;
                            state <= S_SEND;
                        end else if (bit_tick) begin
                            tick_cnt <= tick_cnt + 8'h01; // [R21]
                        end
                    end
                end
                S_KEY: begin
                    if (rx_valid) begin
                        key_byte <= rx_data;
                        key_valid <= 1'b1;
                        byte_cnt <= byte_cnt + 4'h1;
                        if (byte_cnt == need) begin
                            key_done <= 1'b1; // [R19]
                            if (rpt_run && rpt_cnt != 8'h00) begin
                                rpt_cnt <= rpt_cnt - 8'h01; // [R11]
                                state <= S_DEC;
                            end else begin
                                rpt_run <= 1'b0;
                                state <= S_SYNC;
                            end
                        end
                    end
                end
                default: begin
                    state <= S_SYNC;
                end
            endcase
        end
    end

endmodule

// [spd_engine_asserts.sv]
// port checker for the debug instruction engine
module spd_engine_asserts (
    input wire core_clk,
    input wire rst,
    input wire rx_valid,
    input wire rx_break,
    input wire tx_ready,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire bus_req,
    input wire bus_ack,
    input wire [15:0] bus_addr,
    input wire [15:0] bus_wdata,
    input wire key_valid,
    input wire key_done,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] key_cnt;
    wire [2:0] wd_lo = reg_wdata[2:0];
    wire [2:0] rd_lo = reg_rdata[2:0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    always @(posedge core_clk) begin
        if (rst || rx_break || key_done) key_cnt <= 4'h0;
        else if (key_valid) key_cnt <= key_cnt + 4'h1;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_bus_wait;
        bus_req && !bus_ack && !rx_break;
    endsequence
    sequence s_bus_done;
        bus_req && bus_ack;
    endsequence
    sequence s_guard_wr;
        reg_wr && reg_addr == 4'h2 && !rx_valid && !$past(rx_valid);
    endsequence
    property p_bus_hold;
        s_bus_wait |=> bus_req && $stable(bus_addr) && $stable(bus_wdata);
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus request moved early");
    property p_bus_release;
        s_bus_done |=> !bus_req;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus request kept");
    property p_tx_hold;
        tx_valid && !tx_ready && !rx_break |=> tx_valid && $stable(tx_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved early");
    property p_tx_once;
        tx_valid && tx_ready |=> !tx_valid;
    endproperty
    a_tx_once: assert property (p_tx_once) else $error("tx byte offered twice");
    property p_quiet_bus;
        bus_req |-> !tx_valid;
    endproperty
    a_quiet_bus: assert property (p_quiet_bus) else $error("ack before write done");
    property p_key_quiet;
        key_valid |-> !tx_valid && !bus_req;
    endproperty
    a_key_quiet: assert property (p_key_quiet) else $error("reply during key");
    property p_key_count;
        key_done |-> key_valid && key_cnt == 4'h7;
    endproperty
    a_key_count: assert property (p_key_count) else $error("key length wrong");
    property p_guard_rd;
        s_guard_wr ##1 (reg_rd && reg_addr == 4'h2 && !rx_valid) |=> rd_lo == $past(wd_lo, 2);
    endproperty
    a_guard_rd: assert property (p_guard_rd) else $error("guard readback wrong");
endmodule

bind spd_engine spd_engine_asserts u_chk (.core_clk, .rst, .rx_valid, .rx_break, .tx_ready,
    .tx_valid, .tx_data, .bus_req, .bus_ack, .bus_addr, .bus_wdata, .key_valid, .key_done,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

// [spd_phy_model.sv]
// far side model: byte phy, baud ticks, bus slave
module spd_phy_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready = 1'b1,
    output logic bit_tick = 1'b0,
    input wire logic bus_req,
    output logic bus_ack = 1'b0,
    input wire logic bus_slow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx_q[$];
    int rise_q[$];
    int ticks = 0;
    logic [1:0] div = 2'h0;
    logic [3:0] busy = 4'h0;
    logic [3:0] bwait = 4'h0;
    logic txv_d = 1'b0;
    always @(posedge core_clk) begin
        div <= div + 2'h1;
        bit_tick <= (div == 2'h3);
        txv_d <= tx_valid;
        bus_ack <= 1'b0;
        if (bit_tick) ticks <= ticks + 1;
        if (tx_valid && !txv_d) rise_q.push_back(ticks);
        if (rst) begin
            tx_ready <= 1'b1;
            busy <= 4'h0;
            bwait <= 4'h0;
        end else if (tx_valid && tx_ready) begin
            tx_ready <= 1'b0;
            // start, eight data, two idle bits
            busy <= 4'hb;
            tx_q.push_back(tx_data);
        end else if (busy != 4'h0) begin
            if (bit_tick) busy <= busy - 4'h1;
        end else begin
            tx_ready <= 1'b1;
        end
        if (!rst && bus_req && !bus_ack) begin
            bwait <= bwait + 4'h1;
            if (bwait >= (bus_slow ? 4'h9 : 4'h1)) begin
                bus_ack <= 1'b1;
                bwait <= 4'h0;
            end
        end
    end
endmodule

// [spd_engine_test.sv]
// self-checking bench for the debug instruction engine
`include "spd_engine_regs.vh"
module spd_engine_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [3:0] idx; logic [7:0] val;} spd_row_t;
    spd_row_t rows[4] = '{'{4'h3, 8'h80}, '{4'h2, 8'h05}, '{4'h3, 8'h00}, '{4'h2, 8'h07}};
    logic core_clk = 0, rst = 1, rx_valid = 0, rx_break = 0, bus_slow = 0;
    logic reg_wr = 0, reg_rd = 0;
    logic [7:0] rx_data = 8'h00, reg_wdata = 8'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [127:0] sib_data = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
    wire tx_valid, tx_ready, bit_tick, bus_req, bus_ack, bus_word, key_valid, key_done;
    wire [7:0] tx_data, key_byte, reg_rdata;
    wire [15:0] bus_addr, bus_wdata;
    int n_mismatch = 0, checked = 0, cyc = 0, rx_tick = 0, nkey = 0, gbits = 128, d;
    logic [32:0] wr_q[$];
    logic [7:0] key_q[$];
    spd_engine u_dut (.core_clk, .rst, .rx_valid, .rx_data, .rx_break, .bit_tick, .tx_ready,
        .tx_valid, .tx_data, .bus_req, .bus_addr, .bus_wdata, .bus_word, .bus_ack, .key_byte,
        .key_valid, .key_done, .sib_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    spd_phy_model u_phy (.core_clk, .rst, .tx_valid, .tx_data, .tx_ready, .bit_tick,
        .bus_req, .bus_ack, .bus_slow);
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (bus_req && bus_ack) begin
            wr_q.push_back({bus_word, bus_addr, bus_word ? bus_wdata[15:8] : 8'h00,
                bus_wdata[7:0]});
        end
        if (key_valid) key_q.push_back(key_byte);
        if (key_done) nkey <= nkey + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic send_all(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge core_clk);
            rx_valid <= 1'b1;
            rx_data <= q[i];
            @(posedge core_clk);
            rx_valid <= 1'b0;
            rx_tick = u_phy.ticks;
            repeat (3) @(posedge core_clk);
        end
    endtask
    task automatic wait_tx(input int n);
        for (int i = 0; i < 3000 && u_phy.tx_q.size() < n; i++) @(posedge core_clk);
    endtask
    task automatic ack();
        wait_tx(1);
        check(u_phy.tx_q.size(), 1);
        if (u_phy.tx_q.size()) check(u_phy.tx_q.pop_front(), `SPD_ACK_CHAR);
    endtask
    task automatic expw(input logic [32:0] e);
        check(wr_q.size(), 1);
        if (wr_q.size()) check(wr_q.pop_front(), e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask
    task automatic system_info_block(input logic [7:0] instr, input int n, input int gap);
        int b;
        send_all('{`SPD_SYNC_CHAR, instr});
        wait_tx(n);
        check(u_phy.tx_q.size(), n);
        b = u_phy.rise_q.size() - n;
        d = u_phy.rise_q[b] - rx_tick;
        check(d >= gbits && d <= gbits + 2, 1);
        for (int i = 0; i < n; i++) begin
            if (u_phy.tx_q.size()) check(u_phy.tx_q.pop_front(), sib_data[8*i+:8]);
            d = (i > 0) ? u_phy.rise_q[b+i] - u_phy.rise_q[b+i-1] : gap;
            check(d >= gap && d <= gap + 1, 1);
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(`SPD_CS_GUARD, `SPD_GUARD_RESET);
        @(posedge core_clk);
        wr(`SPD_CS_GUARD, 8'h03);
        rd(`SPD_CS_GUARD, 8'h03);
        @(posedge core_clk);
        wr(`SPD_CS_GUARD, 8'h00);
        foreach (rows[i]) begin
            send_all('{8'h55, 8'hc0 | rows[i].idx, rows[i].val});
            repeat (30) @(posedge core_clk);
            check(u_phy.tx_q.size(), 0);
            rd(rows[i].idx, rows[i].val);
            if (rows[i].idx == 4'h2) gbits = &rows[i].val[2:0] ? 0 : 128 >> rows[i].val[2:0];
            send_all('{8'h55, 8'h80 | rows[i].idx});
            wait_tx(1);
            check(u_phy.tx_q.size(), 1);
            if (u_phy.tx_q.size()) check(u_phy.tx_q.pop_front(), rows[i].val);
            d = u_phy.rise_q[$] - rx_tick;
            check(d >= gbits && d <= gbits + 2, 1);
        end
        send_all('{8'h55, 8'h69, 8'h34, 8'h12});
        ack();
        check(wr_q.size(), 0);
        send_all('{8'h55, 8'h64, 8'ha5});
        ack();
        expw({1'b0, 16'h1234, 16'h00a5});
        send_all('{8'h55, 8'h60, 8'h5a});
        ack();
        expw({1'b0, 16'h1235, 16'h005a});
        send_all('{8'h55, 8'h60, 8'h3c});
        ack();
        expw({1'b0, 16'h1235, 16'h003c});
        bus_slow <= 1'b1;
        send_all('{8'h55, 8'ha0, 8'h02, 8'h55, 8'h65});
        for (int i = 0; i < 3; i++) begin
            // next data frame only after the ack
            send_all('{8'h11 + i[7:0], 8'h22});
            ack();
            expw({1'b1, 16'h1235 + 16'(2 * i), 8'h22, 8'h11 + i[7:0]});
        end
        send_all('{8'h77, 8'h88});
        repeat (40) @(posedge core_clk);
        check(wr_q.size() + u_phy.tx_q.size(), 0);
        bus_slow <= 1'b0;
        send_all('{8'h55, 8'ha0, 8'h05, 8'h55, 8'h64, 8'h01});
        ack();
        expw({1'b0, 16'h123b, 16'h0001});
        rx_break <= 1'b1;
        @(posedge core_clk);
        rx_break <= 1'b0;
        send_all('{8'h02});
        repeat (40) @(posedge core_clk);
        check(wr_q.size() + u_phy.tx_q.size(), 0);
        send_all('{8'h55, 8'h64, 8'h03});
        ack();
        expw({1'b0, 16'h123c, 16'h0003});
        send_all('{8'h55, 8'ha0, 8'h01, 8'h55, 8'h40, 8'h10, 8'h99, 8'h10, 8'h98});
        repeat (40) @(posedge core_clk);
        check(wr_q.size() + u_phy.tx_q.size(), 0);
        send_all('{8'h55, 8'he0, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37});
        repeat (40) @(posedge core_clk);
        check({nkey[0], key_q.size()}, {1'b1, 32'd8});
        foreach (key_q[i]) check(key_q[i], 8'h30 + i[7:0]);
        check(u_phy.tx_q.size(), 0);
        gbits = 0;
        send_all('{8'h55, 8'hc3, 8'h80});
        repeat (30) @(posedge core_clk);
        system_info_block(8'he5, 16, 13);
        send_all('{8'h55, 8'hc3, 8'h00});
        repeat (30) @(posedge core_clk);
        system_info_block(8'he4, 8, 11);
        conclude();
    end
endmodule
